//--- watchdog_pkg.sv
// Constants, field layout and types shared by the watchdog control logic.
package watchdog_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_WATCHDOG_CONTROL_STATUS    = 8'hD8;
  localparam logic [7:0] OFF_UNLOCK   = 8'hC0;
  localparam logic [7:0] OFF_IRQ_STAT = 8'hE0;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hE4;
  localparam logic [7:0] OFF_CTRL     = 8'hE8;

  // Bit positions inside the watchdog control and status register.
  localparam int unsigned B_SMOD = 7;
  localparam int unsigned B_POR  = 6;
  localparam int unsigned B_WATCHDOG_INTERRUPT_FLAG = 3;
  localparam int unsigned B_WATCHDOG_RESET_CAUSE_FLAG = 2;
  localparam int unsigned B_EWT  = 1;
  localparam int unsigned B_RWT  = 0;

  // Bits that need the unlock window, and bits that are always writable.
  localparam logic [7:0] PROT_MASK = 8'h4B;
  localparam logic [7:0] FREE_MASK = 8'h84;
  // Bits kept across an external reset (pattern 0x0x0xx0).
  localparam logic [7:0] EXT_KEEP  = 8'h56;
  // Power-on value: only the power-up flag is set.
  localparam logic [7:0] WATCHDOG_CONTROL_STATUS_POR = 8'h40;

  // Unlock keys and window length.
  localparam logic [7:0] UNLOCK_KEY1  = 8'hAA;
  localparam logic [7:0] UNLOCK_KEY2  = 8'h55;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MC_CLKS      = 4;
  localparam int unsigned UNLOCK_MC    = 3;
  localparam logic [3:0] UNLOCK_CLKS  = 4'(MC_CLKS * UNLOCK_MC);

  // Timing of the watchdog.
  localparam logic [9:0] RST_DELAY_CLKS  = 10'd512;
  localparam int unsigned WDT_TIMEOUT_DEF = 131072;

  // Interrupt event bit positions and control bit positions.
  localparam int unsigned EV_TIMEOUT = 0;
  localparam int unsigned EV_WDT_RST = 1;
  localparam int unsigned C_WDI_EN   = 0;

  // Field layout of the watchdog control and status register.
  typedef struct packed {
    logic       serial1_rate_double;
    logic       power_up_flag;
    logic [1:0] rsv;
    logic       watchdog_interrupt_flag;
    logic       watchdog_reset_cause_flag;
    logic       watchdog_reset_enable;
    logic       watchdog_restart;
  } watchdog_control_status_t;

  // Watchdog sequencing states.
  typedef enum logic {
    WD_RUN,
    WD_PEND
  } wd_state_t;

endpackage

//--- watchdog_control_flags.sv
// Watchdog control, status flags, timed unlock and timeout sequencing.
//
// Chosen here: the APB interface to the registers.
module watchdog_control_flags
  import watchdog_pkg::*;
#(
  parameter int unsigned TIMEOUT_CLKS = WDT_TIMEOUT_DEF
)
(
  // Clock, power-on reset and freeze.
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  // Reset causes arriving on pins.
  input  wire logic        EXT_RST_N,
  input  wire logic        PFAIL_RST_N,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Serial port 1 mode and rate control.
  input  wire logic [1:0]  SER1_MODE,
  output logic             SER1_RATE_DOUBLE,
  // Watchdog outputs.
  output logic             WDT_INT_REQ,
  output logic             WDT_RESET,
  output logic             IRQ
);

  // Decodes whether an offset is a mapped register.
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == OFF_WATCHDOG_CONTROL_STATUS) || (a == OFF_UNLOCK) ||
               (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK) ||
               (a == OFF_CTRL);
  endfunction

  localparam logic [31:0] TO_LAST = 32'(TIMEOUT_CLKS - 1);

  // Operating notes for the next engineer on this block.
  //
  // Register map, all registers at most eight bits wide in the low byte of a word.
  // The control and status register holds the rate doubling bit in bit 7.
  // Bit 6 is the power-up flag, set by the power-on reset and writable inside the unlock window.
  // Bits 5 and 4 are unused and always read as zero.
  // Bit 3 is the watchdog interrupt flag, set by a timeout.
  // Bit 2 is the reset cause flag, set when the watchdog resets the device.
  // Bit 1 is the reset enable, which arms the delayed device reset.
  // Bit 0 is the restart strobe, which reads as one for a single cycle.
  // The unlock register takes the two keys and reads back the window state.
  // The event status register collects timeout and watchdog reset events.
  // The event mask register selects which events drive the level interrupt.
  // The control register holds the watchdog interrupt enable in bit 0.
  // Any other offset answers with an error and reads as zero.
  //
  // Bus timing.
  // The slave never inserts wait states, so ready is tied high.
  // Writes land at the clock edge that closes the access phase.
  // Read data is captured at the edge that closes the setup phase.
  // Capturing early keeps the read path a plain flop, at the cost of
  // showing the value as it stood one cycle before the access edge.
  // Upper data bits are ignored on writes and read back as zero.
  //
  // Unlock sequence.
  // The first key must be the very next write before the second key.
  // Any other write in between drops the first key, reads do not.
  // After the second key the window stays open for three machine cycles.
  // A machine cycle is four clocks, so the window covers twelve clocks.
  // Protected bits written while the window is shut keep their value.
  // The window is not closed by a protected write, so software may
  // update several protected bits with back to back transfers.
  //
  // Watchdog sequencing.
  // The counter runs from zero up to one less than the configured timeout length.
  // On its last count the interrupt flag and the timeout event are set.
  // The block then waits a fixed number of clocks before acting.
  // If the reset enable is still set at the end of that wait, a single
  // cycle reset pulse leaves the block and the cause flag is raised.
  // If the reset enable is clear, the wait ends quietly and the counter
  // starts over, so the interrupt flag and the timeout event are the only trace of the timeout.
  // A restart strobe inside the window zeroes the counter at once and
  // cancels any reset that is still pending.
  // The timeout length is a parameter because it depends on the clock
  // divider chosen by the surrounding device.
  //
  // Reset causes.
  // The power-on reset is the asynchronous reset input of this block.
  // It loads the control register with only the power-up flag set.
  // The external and power-fail reset pins are synchronised first.
  // While either pin stays low the register is masked every cycle.
  // The external reset keeps the power-up flag, the cause flag and the
  // reset enable, and clears every other bit.
  // The power-fail reset does the same and also clears the cause flag.
  // Both pin resets restart the counter so no stale timeout survives.
  // The watchdog reset itself masks the register like an external reset
  // and then sets the cause flag.
  //
  // Interrupts.
  // The event status bits are sticky and cleared by writing ones.
  // When an event and a clear meet in one cycle the event wins, so no
  // event is ever lost to a late clear.
  // The level interrupt is high while any unmasked event bit is set.
  // The watchdog interrupt request follows the interrupt flag, gated by
  // the watchdog interrupt enable.
  //
  // Clock enable.
  // While the clock enable is low every flop holds its value.
  // Bus writes arriving then are ignored, so software must not access
  // the block while it is frozen.
  //
  // Serial rate doubling.
  // The doubling output is only active in serial modes one to three.
  // Mode zero runs at a fixed rate, so the bit has no effect there.
  //
  // Hazards.
  // A restart strobe and a timeout in the same cycle favour the restart.
  // A restart strobe and the end of the delay in the same cycle favour
  // the restart, so the device reset is not generated.
  // A pin reset during the delay cancels the pending device reset.
  // The synchronisers idle high, so no false reset follows power-on.

  logic       ext_meta_r;
  logic       ext_sync_r;
  logic       pf_meta_r;
  logic       pf_sync_r;
  logic       ext_rst;
  logic       pf_rst;
  logic       acc;
  logic       wr;
  logic [7:0] wdat;
  logic       wr_watchdog_control_status;
  logic       wr_unlock;
  logic       key1_r;
  logic [3:0] win_cnt_r;
  logic       win_open;
  logic [7:0] wmask;
  watchdog_control_status_t     watchdog_control_status_r;
  watchdog_control_status_t     watchdog_control_status_nxt;
  logic       restart_req;
  logic       restart;
  wd_state_t  state_r;
  logic [31:0] cnt_r;
  logic [9:0] dly_r;
  logic       timeout;
  logic       fire;
  logic       wdt_rst_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [1:0] ctrl_r;
  logic [31:0] prdata_r;

  // Two-flop synchronisers for the reset-cause pins.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_meta_r <= 1'b1;
      ext_sync_r <= 1'b1;
      pf_meta_r  <= 1'b1;
      pf_sync_r  <= 1'b1;
    end else if (CE) begin
      ext_meta_r <= EXT_RST_N;
      ext_sync_r <= ext_meta_r;
      pf_meta_r  <= PFAIL_RST_N;
      pf_sync_r  <= pf_meta_r;
    end
  end

  assign ext_rst = ~ext_sync_r;
  assign pf_rst  = ~pf_sync_r;

  // Bus decode; the slave never waits, unmapped offsets answer with an error.
  assign acc       = PSEL & PENABLE;
  assign wr        = acc & PWRITE & CE;
  assign wdat      = PWDATA[7:0];
  assign wr_watchdog_control_status  = wr & (PADDR == OFF_WATCHDOG_CONTROL_STATUS);
  assign wr_unlock = wr & (PADDR == OFF_UNLOCK);
  assign PREADY    = 1'b1;
  assign PSLVERR   = acc & ~addr_hit(PADDR);

  // First unlock key; any other write in between breaks the sequence.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      key1_r <= 1'b0;
    end else if (wr) begin
      key1_r <= wr_unlock & (wdat == UNLOCK_KEY1);
    end
  end

  // Unlock window counts down three machine cycles after the second key.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      win_cnt_r <= 4'h0;
    end else if (CE) begin
      if (wr_unlock && key1_r && wdat == UNLOCK_KEY2) begin
        win_cnt_r <= UNLOCK_CLKS;
      end else if (win_cnt_r != 4'h0) begin
        win_cnt_r <= win_cnt_r - 4'h1;
      end
    end
  end

  assign win_open = (win_cnt_r != 4'h0);
  // Protected bits are writable only inside the window.
  assign wmask = FREE_MASK | (win_open ? PROT_MASK : 8'h00);

  // A restart write is accepted only with the window open.
  assign restart_req = wr_watchdog_control_status & win_open & wdat[B_RWT];
  assign restart     = restart_req | ext_rst | pf_rst | fire;

  // Next value of the control register under normal software access.
  always_comb begin
    watchdog_control_status_nxt = watchdog_control_status_r;
    if (wr_watchdog_control_status) begin
      watchdog_control_status_nxt = watchdog_control_status_t'((watchdog_control_status_r & ~wmask) | (wdat & wmask));
    end
    watchdog_control_status_nxt.rsv = 2'b00;
    watchdog_control_status_nxt.watchdog_restart = restart_req;
    if (timeout) begin
      watchdog_control_status_nxt.watchdog_interrupt_flag = 1'b1;
    end
  end

  // Control register with the reset-type dependent values.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      watchdog_control_status_r <= watchdog_control_status_t'(WATCHDOG_CONTROL_STATUS_POR);
    end else if (CE) begin
      if (pf_rst) begin
        watchdog_control_status_r <= watchdog_control_status_t'(watchdog_control_status_r & EXT_KEEP);
        watchdog_control_status_r.watchdog_reset_cause_flag <= 1'b0;
      end else if (ext_rst) begin
        watchdog_control_status_r <= watchdog_control_status_t'(watchdog_control_status_r & EXT_KEEP);
      end else if (fire) begin
        watchdog_control_status_r <= watchdog_control_status_t'(watchdog_control_status_r & EXT_KEEP);
        watchdog_control_status_r.watchdog_reset_cause_flag <= 1'b1;
      end else begin
        watchdog_control_status_r <= watchdog_control_status_nxt;
      end
    end
  end

  // Timeout is reached on the last count unless a restart lands now.
  assign timeout = CE & (state_r == WD_RUN) & (cnt_r == TO_LAST) & ~restart;
  // The reset fires 512 clocks after the timeout, only when enabled.
  assign fire = CE & (state_r == WD_PEND) & (dly_r == RST_DELAY_CLKS - 10'd1) &
                watchdog_control_status_r.watchdog_reset_enable & ~restart_req & ~ext_rst & ~pf_rst;

  // Watchdog counter and post-timeout delay sequencing.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= WD_RUN;
      cnt_r   <= 32'h0000_0000;
      dly_r   <= 10'h000;
    end else if (CE) begin
      if (restart) begin
        state_r <= WD_RUN;
        cnt_r   <= 32'h0000_0000;
        dly_r   <= 10'h000;
      end else begin
        case (state_r)
          WD_RUN: begin
            if (cnt_r == TO_LAST) begin
              state_r <= WD_PEND;
              cnt_r   <= 32'h0000_0000;
              dly_r   <= 10'h000;
            end else begin
              cnt_r <= cnt_r + 32'h0000_0001;
            end
          end
          WD_PEND: begin
            if (dly_r == RST_DELAY_CLKS - 10'd1) begin
              state_r <= WD_RUN;
              dly_r   <= 10'h000;
            end else begin
              dly_r <= dly_r + 10'h001;
            end
          end
          default: begin
            state_r <= WD_RUN;
          end
        endcase
      end
    end
  end

  // One-cycle watchdog reset pulse to the rest of the device.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wdt_rst_r <= 1'b0;
    end else if (CE) begin
      wdt_rst_r <= fire;
    end
  end

  // Sticky event bits, write one to clear; a new event wins over the clear.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stat_r <= 2'b00;
    end else if (CE) begin
      stat_r[EV_TIMEOUT] <= timeout |
        (stat_r[EV_TIMEOUT] & ~(wr && PADDR == OFF_IRQ_STAT && wdat[EV_TIMEOUT]));
      stat_r[EV_WDT_RST] <= fire |
        (stat_r[EV_WDT_RST] & ~(wr && PADDR == OFF_IRQ_STAT && wdat[EV_WDT_RST]));
    end
  end

  // Interrupt mask and watchdog interrupt enable registers.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask_r <= 2'b00;
      ctrl_r <= 2'b00;
    end else if (wr) begin
      if (PADDR == OFF_IRQ_MASK) begin
        mask_r <= wdat[1:0];
      end
      if (PADDR == OFF_CTRL) begin
        ctrl_r <= {1'b0, wdat[C_WDI_EN]};
      end
    end
  end

  // Read data is captured in the setup phase, so reads never wait.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_r <= 32'h0000_0000;
    end else if (CE && PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        OFF_WATCHDOG_CONTROL_STATUS:    prdata_r <= {24'h000000, watchdog_control_status_r};
        OFF_UNLOCK:   prdata_r <= {31'h0000_0000, win_open};
        OFF_IRQ_STAT: prdata_r <= {30'h0000_0000, stat_r};
        OFF_IRQ_MASK: prdata_r <= {30'h0000_0000, mask_r};
        OFF_CTRL:     prdata_r <= {30'h0000_0000, ctrl_r};
        default:      prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Outputs.
  assign PRDATA           = prdata_r;
  assign SER1_RATE_DOUBLE = watchdog_control_status_r.serial1_rate_double & (SER1_MODE != 2'b00);
  assign WDT_INT_REQ      = watchdog_control_status_r.watchdog_interrupt_flag & ctrl_r[C_WDI_EN];
  assign WDT_RESET        = wdt_rst_r;
  assign IRQ              = |(stat_r & mask_r);

endmodule

//--- watchdog_control_flags_checker.sv
// Port-level assertions for the watchdog control block.
module watchdog_control_flags_checker
  import watchdog_pkg::*;
(
  // Clock and reset.
  input wire logic        CLK,
  input wire logic        ARST_N,
  // Bus and outputs watched.
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [1:0]  SER1_MODE,
  input wire logic        SER1_RATE_DOUBLE,
  input wire logic        WDT_RESET,
  input wire logic        IRQ
);
  logic unmapped;

  // Flags an address that no register answers to.
  assign unmapped = !(PADDR inside {OFF_WATCHDOG_CONTROL_STATUS, OFF_UNLOCK, OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_CTRL});

  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // The reset request is a single-cycle pulse.
  sequence s_pulse;
    WDT_RESET ##1 !WDT_RESET;
  endsequence

  a_ready_high: assert property (PREADY) else $error("PREADY low");
  a_err_phase: assert property (PSLVERR |-> PSEL && PENABLE) else $error("PSLVERR outside access");
  a_err_unmapped: assert property (PSEL && PENABLE && unmapped |-> PSLVERR) else $error("no PSLVERR");
  a_unmapped_zero: assert property (PSEL && PENABLE && !PWRITE && unmapped |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (PRDATA[31:8] == 24'h0) else $error("upper read bits set");
  a_rate_mode: assert property (SER1_MODE == 2'h0 |-> !SER1_RATE_DOUBLE) else $error("doubling in mode 0");
  a_reset_single: assert property ($rose(WDT_RESET) |-> s_pulse) else $error("reset pulse too long");
  a_quiet_reset: assert property (@(posedge CLK) disable iff (1'b0) !ARST_N |-> !WDT_RESET && !IRQ && PRDATA == 32'h0)
    else $error("outputs active in reset");
endmodule

bind watchdog_control_flags watchdog_control_flags_checker i_chk (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SER1_MODE(SER1_MODE), .SER1_RATE_DOUBLE(SER1_RATE_DOUBLE), .WDT_RESET(WDT_RESET), .IRQ(IRQ));

//--- tb.sv
// Self-checking testbench for the watchdog control block.
module tb;
  import watchdog_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 200;
  logic        clk = 0, arst_n = 1, ext_n = 1, pfail_n = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  mode = 2'h0;
  logic        pready, pslverr, rate, int_req, wdt_rst, irq;
  int          errors = 0, samples_checked = 0, n;

  watchdog_control_flags #(.TIMEOUT_CLKS(TMO)) i_watchdog_control_flags (.CLK(clk), .ARST_N(arst_n), .CE(1'b1),
    .EXT_RST_N(ext_n), .PFAIL_RST_N(pfail_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SER1_MODE(mode),
    .SER1_RATE_DOUBLE(rate), .WDT_INT_REQ(int_req), .WDT_RESET(wdt_rst), .IRQ(irq));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer: setup cycle, then access until ready.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Reads a register and compares the masked bits.
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd & {24'h0, m}, exp);
  endtask

  task automatic unlock();
    wr(OFF_UNLOCK, 32'h0000_00AA);
    wr(OFF_UNLOCK, 32'h0000_0055);
  endtask

  // Holds one reset pin low long enough to pass its synchroniser.
  task automatic pin_pulse(input bit ext);
    if (ext) ext_n <= 1'b0;
    else pfail_n <= 1'b0;
    repeat (4) @(posedge clk);
    ext_n <= 1'b1;
    pfail_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short well after the expected run length.
  initial begin
    #100us;
    errors++;
    summarize();
  end

  // Main sequence of tests.
  initial begin
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'hF7, 32'h40);
    bus(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    wr(OFF_WATCHDOG_CONTROL_STATUS, 32'hFF);
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'hF7, 32'hC4);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      mode <= 2'(m);
      #1;
      chk(32'(rate), 32'(m != 0));
    end
    $display("test access done");
    unlock();
    wr(OFF_WATCHDOG_CONTROL_STATUS, 32'h03);
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'hF7, 32'h02);
    wr(OFF_UNLOCK, 32'h0000_00AA);
    wr(OFF_IRQ_MASK, 32'h12);
    wr(OFF_UNLOCK, 32'h0000_0055);
    wr(OFF_WATCHDOG_CONTROL_STATUS, 32'h40);
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'hF7, 32'h02);
    $display("test unlock done");
    wr(OFF_CTRL, 32'h1);
    wr(OFF_IRQ_MASK, 32'h3);
    wr(OFF_IRQ_STAT, 32'h3);
    unlock();
    wr(OFF_WATCHDOG_CONTROL_STATUS, 32'h03);
    n = 0;
    while (int_req !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n), 32'(TMO));
    n = 0;
    while (wdt_rst !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n), 32'd512);
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'hF7, 32'h06);
    rdc(OFF_IRQ_STAT, 8'hFF, 32'h3);
    chk(32'(irq), 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    #1;
    chk(32'(irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h3);
    wr(OFF_IRQ_STAT, 32'h3);
    #1;
    chk(32'(irq), 32'h0);
    $display("test timeout done");
    wr(OFF_WATCHDOG_CONTROL_STATUS, 32'h84);
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'hF7, 32'h86);
    pin_pulse(1'b1);
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'hF7, 32'h06);
    pin_pulse(1'b0);
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'hF7, 32'h02);
    $display("test resets done");
    unlock();
    wr(OFF_WATCHDOG_CONTROL_STATUS, 32'h01);
    n = 0;
    repeat (800) begin
      @(posedge clk);
      #1;
      if (wdt_rst === 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    rdc(OFF_WATCHDOG_CONTROL_STATUS, 8'h0C, 32'h08);
    $display("test disabled done");
    summarize();
  end
endmodule
